// ---- core/card_response_status_framer.sv ----
// Purpose : Builds card responses and shifts them out on the command line
// Assumes : Link clock sampled by i_ref_clk, at least 8x slower
// Notes   : Bits change after a link falling edge, host samples on rise
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Responses go out serially, leftmost codeword bit first.
// - Every response starts with start bit 0 then direction bit 0.
// - Every response ends with an end bit of 1.
// - Bits 7..1 carry CRC7, except the operating-conditions and register responses.
// - Normal response: 48 bits, index in 45..40, status in 39..8.
// - Data-line busy after written blocks belongs to the data path.
// - Busy variant uses the normal format; busy handled on data line.
// - Register response: 136 bits, 133..128 ones, register bits 127..1.
// - OCR response: 48 bits, index and CRC fields all ones.
// - Address response: index 3, RCA in 39..24, selected status bits.
// - Status reflects the outcome of the previous command.
// - Class A follows state, B clears one command late, C on read.
// - Bits found during execution are latched until read.
// - Bits 31..26 are clear-on-read fault flags.
// - Bit 25 follows lock state; bit 24 flags lock sequence fault.
// - Bits 23 and 22 flag checksum and illegal command, class B.
// - Bits 21, 20, 19 flag ECC, controller and general faults.
// - Bit 16 flags a rejected register rewrite, clear on read.
// - Bits 15, 14, 13: erase skip, ECC off, erase cancel.
// - Bits 12..9 hold card state at command receipt.
// - Bit 8 follows the empty data buffer.
// - Bits 5 and 3: application command and authentication fault.
module card_response_status_framer
   import resp_framer_pkg::*;
(
   // Clock and reset
   input  wire logic                            i_ref_clk,
   input  wire logic                            i_rst,
   // Command line, link side
   input  wire logic                            i_link_clk,
   input  wire logic                            i_cmd_in,
   output logic                                 o_cmd_out,
   output logic                                 o_cmd_oe_n,
   // Response request
   input  wire logic                            i_resp_valid,
   input  wire resp_framer_pkg::resp_req_t      i_resp,
   output logic                                 o_resp_ready,
   output logic                                 o_resp_done,
   // Status sources
   input  wire logic                            i_cmd_strobe,
   input  wire logic                            i_cmd_ok,
   input  wire logic [3:0]                      i_card_state,
   input  wire resp_framer_pkg::status_events_t i_events,
   input  wire resp_framer_pkg::status_levels_t i_levels,
   output logic [31:0]                          o_status_word
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------

   // Map event pulses onto their status bit positions
   function automatic logic [31:0] event_word(input status_events_t e);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[31] = e.arg_range_fault;
      w[30] = e.misaligned_addr_fault;
      w[29] = e.block_length_fault;
      w[28] = e.erase_order_fault;
      w[27] = e.erase_selection_fault;
      w[26] = e.protected_write_fault;
      w[24] = e.lock_sequence_fault;
      w[23] = e.command_checksum_fault;
      w[22] = e.illegal_cmd_fault;
      w[21] = e.ecc_uncorrected_fault;
      w[20] = e.controller_internal_fault;
      w[19] = e.general_fault;
      w[16] = e.specific_data_rewrite_fault;
      w[15] = e.erase_skip_flag;
      w[13] = e.erase_cancel_flag;
      w[5]  = e.app_cmd_flag;
      w[3]  = e.authentication_order_fault;
      return w;
   endfunction : event_word

   // Sticky bits merged with the state-following fields
   function automatic logic [31:0] compose(
      input logic [31:0]    sticky,
      input status_levels_t lv,
      input logic [3:0]     st
   );
      logic [31:0] w;
      w = sticky;
      w[LOCKED_POS]    = lv.locked_flag;
      w[ECC_OFF_POS]   = lv.ecc_off_flag;
      w[BUF_EMPTY_POS] = lv.buffer_empty_flag;
      w[STATE_LSB +: 4] = st;
      return w;
   endfunction : compose

   // Lay the codeword out, less the live CRC7 field, right-aligned in the frame register
   function automatic logic [FRAME_W-1:0] build_frame(
      input resp_req_t   r,
      input logic [31:0] sw
   );
      logic [FRAME_W-1:0] f;
      f = '0;
      unique case (r.kind)
         RESP_R2:
         begin
            f[135]     = START_BIT;
            f[134]     = DIR_BIT;
            f[133:128] = ALL_ONES_IDX;
            f[127:1]   = r.reg_bits[127:1];
         end
         RESP_R3:
         begin
            f[47]    = START_BIT;
            f[46]    = DIR_BIT;
            f[45:40] = ALL_ONES_IDX;
            f[39:8]  = r.ocr_word;
            f[7:1]   = NO_CRC_FILL;
         end
         RESP_R6:
         begin
            f[47]    = START_BIT;
            f[46]    = DIR_BIT;
            f[45:40] = RCA_INDEX;
            f[39:24] = r.rca;
            f[23:8]  = {sw[23], sw[22], sw[19], sw[12:0]};
         end
         RESP_R1, RESP_R1B:
         begin
            // Data-line busy of the busy variant is driven elsewhere
            f[47]    = START_BIT;
            f[46]    = DIR_BIT;
            f[45:40] = r.cmd_index;
            f[39:8]  = sw;
         end
         default:
         begin
            f[47] = START_BIT;
            f[46] = DIR_BIT;
         end
      endcase
      f[0] = END_BIT;
      return f;
   endfunction : build_frame

   // ----------------------------------------------------------------
   // Link clock synchroniser and falling edge detect
   // ----------------------------------------------------------------
   logic [1:0] link_sync_reg;
   logic       link_prev_reg;
   logic       link_fall;

   // First stage feeds only the second stage
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         link_sync_reg <= 2'h3;
         link_prev_reg <= 1'b1;
      end
      else
      begin
         link_sync_reg <= {link_sync_reg[0], i_link_clk};
         link_prev_reg <= link_sync_reg[1];
      end
   end

   assign link_fall = link_prev_reg & ~link_sync_reg[1];

   // ----------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------
   logic [31:0] status_reg,    status_next;
   logic [3:0]  state_reg,     state_next;
   logic        clr_arm_reg,   clr_arm_next;
   logic [31:0] view_reg;
   logic [31:0] live_word;
   logic        accept;
   logic        frame_end;
   logic [31:0] read_mask;

   assign live_word = compose(status_reg, i_levels, state_reg);

   // Which bits a response reads, and so which bits it clears
   always_comb
   begin
      read_mask = 32'h0000_0000;
      if (i_resp.kind == RESP_R1 || i_resp.kind == RESP_R1B)
         read_mask = 32'hFFFF_FFFF;
      else if (i_resp.kind == RESP_R6)
         read_mask = R6_MASK;
   end

   // Clears first, sets last, so an event never loses to a clear
   always_comb
   begin
      status_next  = status_reg;
      state_next   = state_reg;
      clr_arm_next = clr_arm_reg;
      if (frame_end && clr_arm_reg)
      begin
         status_next  = status_next & ~CLASS_B_MASK;
         clr_arm_next = 1'b0;
      end
      if (accept)
         status_next = status_next & ~(CLASS_C_MASK & read_mask);
      if (i_cmd_strobe)
         state_next = i_card_state;
      if (i_cmd_strobe && i_cmd_ok)
         clr_arm_next = 1'b1;
      status_next = status_next | event_word(i_events);
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         status_reg  <= STATUS_RESET;
         state_reg   <= STATE_RESET;
         clr_arm_reg <= 1'b0;
         view_reg    <= STATUS_RESET;
      end
      else
      begin
         status_reg  <= status_next;
         state_reg   <= state_next;
         clr_arm_reg <= clr_arm_next;
         view_reg    <= live_word;
      end
   end

   assign o_status_word = view_reg;

   // ----------------------------------------------------------------
   // Response shifter
   // ----------------------------------------------------------------
   fsm_state_t         fsm_reg,     fsm_next;
   logic [FRAME_W-1:0] frame_reg,   frame_next;
   logic [7:0]         idx_reg,     idx_next;
   logic [6:0]         crc_reg,     crc_next;
   logic               use_crc_reg, use_crc_next;
   logic               out_reg,     out_next;
   logic               oe_n_reg,    oe_n_next;
   logic               done_reg,    done_next;
   logic               cur_bit;
   logic               crc_fb;
   logic [7:0]         nxt_idx;

   assign accept    = (fsm_reg == ST_IDLE) && i_resp_valid;
   assign frame_end = done_reg;

   // CRC field is substituted live, so the frame holds zeros there
   always_comb
   begin
      if (use_crc_reg && idx_reg <= CRC_TOP && idx_reg >= CRC_BOT)
         cur_bit = crc_reg[3'(idx_reg - CRC_BOT)];
      else
         cur_bit = frame_reg[idx_reg];
   end

   assign crc_fb  = cur_bit ^ crc_reg[6];
   assign nxt_idx = idx_reg - 8'h01;

   // One bit leaves per link falling edge, top position first
   always_comb
   begin
      fsm_next     = fsm_reg;
      frame_next   = frame_reg;
      idx_next     = idx_reg;
      crc_next     = crc_reg;
      use_crc_next = use_crc_reg;
      out_next     = out_reg;
      oe_n_next    = oe_n_reg;
      done_next    = 1'b0;
      unique case (fsm_reg)
         ST_IDLE:
         begin
            if (i_resp_valid)
            begin
               frame_next   = build_frame(i_resp, live_word);
               idx_next     = (i_resp.kind == RESP_R2) ? LONG_LAST
                                                       : SHORT_LAST;
               use_crc_next = (i_resp.kind != RESP_R3) &&
                              (i_resp.kind != RESP_R2);
               crc_next     = CRC_RESET;
               fsm_next     = ST_ARM;
            end
         end
         ST_ARM:
         begin
            if (link_fall)
            begin
               out_next  = cur_bit;
               oe_n_next = 1'b0;
               fsm_next  = ST_SEND;
            end
         end
         ST_SEND:
         begin
            if (link_fall)
            begin
               // Fold in the bit that was just on the line
               if (idx_reg > CRC_TOP)
                  crc_next = {crc_reg[5:0], 1'b0} ^
                             (crc_fb ? CRC_POLY : 7'h00);
               if (idx_reg == 8'h00)
               begin
                  out_next  = IDLE_LEVEL;
                  oe_n_next = 1'b1;
                  done_next = 1'b1;
                  fsm_next  = ST_IDLE;
               end
               else
               begin
                  // Next bit leaves on this same fall, so each bit
                  // stands exactly one link period
                  idx_next = nxt_idx;
                  if (use_crc_reg && nxt_idx <= CRC_TOP &&
                      nxt_idx >= CRC_BOT)
                     out_next = crc_next[3'(nxt_idx - CRC_BOT)];
                  else
                     out_next = frame_reg[nxt_idx];
               end
            end
         end
         default:
         begin
            fsm_next = ST_IDLE;
         end
      endcase
   end

   // ARM drives the first bit on the first fall; SEND drives every later bit
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         fsm_reg     <= ST_IDLE;
         frame_reg   <= '0;
         idx_reg     <= 8'h00;
         crc_reg     <= CRC_RESET;
         use_crc_reg <= 1'b0;
         out_reg     <= IDLE_LEVEL;
         oe_n_reg    <= 1'b1;
         done_reg    <= 1'b0;
      end
      else
      begin
         fsm_reg     <= fsm_next;
         frame_reg   <= frame_next;
         idx_reg     <= idx_next;
         crc_reg     <= crc_next;
         use_crc_reg <= use_crc_next;
         out_reg     <= out_next;
         oe_n_reg    <= oe_n_next;
         done_reg    <= done_next;
      end
   end

   // Outputs
   assign o_cmd_out    = out_reg;
   assign o_cmd_oe_n   = oe_n_reg;
   assign o_resp_ready = (fsm_reg == ST_IDLE);
   assign o_resp_done  = done_reg;

endmodule : card_response_status_framer

`default_nettype wire

// ---- core/resp_framer_pkg.sv ----
// Purpose : Shared constants and types of the card response framer
// Assumes : One response in flight at a time
// Notes   : Frame positions are bit numbers inside the response codeword
package resp_framer_pkg;

   // ----------------------------------------------------------------
   // Frame geometry
   // ----------------------------------------------------------------
   localparam int          FRAME_W      = 136;
   localparam logic [7:0]  SHORT_LAST   = 8'h2F;  // 48-bit frame, top bit
   localparam logic [7:0]  LONG_LAST    = 8'h87;  // 136-bit frame, top bit
   localparam logic [7:0]  CRC_TOP      = 8'h07;
   localparam logic [7:0]  CRC_BOT      = 8'h01;
   localparam logic [6:0]  CRC_POLY     = 7'h09;  // x^7 + x^3 + 1
   localparam logic [6:0]  CRC_RESET    = 7'h00;
   localparam logic [5:0]  ALL_ONES_IDX = 6'h3F;
   localparam logic [5:0]  RCA_INDEX    = 6'h03;
   localparam logic [6:0]  NO_CRC_FILL  = 7'h7F;
   localparam logic        START_BIT    = 1'b0;
   localparam logic        DIR_BIT      = 1'b0;
   localparam logic        END_BIT      = 1'b1;
   localparam logic        IDLE_LEVEL   = 1'b1;

   // ----------------------------------------------------------------
   // Status word layout
   // ----------------------------------------------------------------
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [31:0] CLASS_C_MASK = 32'hFD39_A028;
   localparam logic [31:0] CLASS_B_MASK = 32'h00C0_0000;
   localparam logic [31:0] R6_MASK      = 32'h00C8_1FFF;
   localparam int          LOCKED_POS   = 25;
   localparam int          ECC_OFF_POS  = 14;
   localparam int          BUF_EMPTY_POS = 8;
   localparam int          STATE_LSB    = 9;
   localparam logic [3:0]  STATE_RESET  = 4'h0;

   typedef enum logic [2:0] {
      RESP_R1  = 3'h0,
      RESP_R1B = 3'h1,
      RESP_R2  = 3'h2,
      RESP_R3  = 3'h3,
      RESP_R6  = 3'h4
   } resp_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_ARM  = 3'h2,
      ST_SEND = 3'h4
   } fsm_state_t;

   typedef struct packed {
      resp_kind_t    kind;
      logic [5:0]    cmd_index;
      logic [31:0]   ocr_word;
      logic [15:0]   rca;
      logic [127:0]  reg_bits;
   } resp_req_t;

   // One-cycle event pulses, each sets one sticky status bit
   typedef struct packed {
      logic arg_range_fault;
      logic misaligned_addr_fault;
      logic block_length_fault;
      logic erase_order_fault;
      logic erase_selection_fault;
      logic protected_write_fault;
      logic lock_sequence_fault;
      logic command_checksum_fault;
      logic illegal_cmd_fault;
      logic ecc_uncorrected_fault;
      logic controller_internal_fault;
      logic general_fault;
      logic specific_data_rewrite_fault;
      logic erase_skip_flag;
      logic erase_cancel_flag;
      logic app_cmd_flag;
      logic authentication_order_fault;
   } status_events_t;

   // Levels that follow the card state
   typedef struct packed {
      logic locked_flag;
      logic ecc_off_flag;
      logic buffer_empty_flag;
   } status_levels_t;

endpackage : resp_framer_pkg

// ---- verif/host_link_model.sv ----
// Purpose : Host side of the command line, link clock and capture
// Assumes : Line pulled up whenever the card releases it
// Notes   : Clock stands high between frames
`timescale 1ns/10ps
`default_nettype none
module host_link_model
(
   // Command line
   input wire logic i_cmd_wire,
   output var logic o_link_clk
);
   import resp_framer_pkg::*;
   // Idle level of the stopped clock
   initial o_link_clk = 1'b1;
   // One period per bit; the card moves on the fall, host samples the rise
   task automatic capture(input int n, output logic [135:0] f);
      int k;
      int w;
      f = '0;
      k = 0;
      w = 0;
      #13;
      while (k < n && w < 16)
      begin
         o_link_clk = 1'b0;
         #200;
         o_link_clk = 1'b1;
         if (k > 0 || i_cmd_wire === START_BIT)
         begin
            f = {f[134:0], i_cmd_wire};
            k++;
         end
         else
            w++;
         #200;
      end
      // Extra periods so the card sees the fall that frees the line
      repeat (3)
      begin
         o_link_clk = 1'b0;
         #200;
         o_link_clk = 1'b1;
         #200;
      end
   endtask : capture
endmodule : host_link_model
`default_nettype wire

// ---- verif/resp_framer_chk.sv ----
// Purpose : Port checks of the card response framer
// Assumes : One clock domain, bound to the framer top
// Notes   : Status checks allow the one-cycle register delay
`timescale 1ns/10ps
`default_nettype none
module resp_framer_chk
(
   // Clock and reset
   input wire logic                            i_ref_clk,
   input wire logic                            i_rst,
   // Watched ports
   input wire logic                            i_resp_valid,
   input wire resp_framer_pkg::status_events_t i_events,
   input wire resp_framer_pkg::status_levels_t i_levels,
   input wire logic                            o_cmd_out,
   input wire logic                            o_cmd_oe_n,
   input wire logic                            o_resp_ready,
   input wire logic                            o_resp_done,
   input wire logic [31:0]                     o_status_word
);
   import resp_framer_pkg::*;
   // ------
   // Framing
   // ------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   sequence s_take; i_resp_valid && o_resp_ready; endsequence
   sequence s_free; $rose(o_cmd_oe_n); endsequence
   property p_busy; s_take |=> !o_resp_ready && o_cmd_oe_n; endproperty
   a_busy: assert property (p_busy) else $error("taken while busy");
   property p_start; $fell(o_cmd_oe_n) |-> o_cmd_out == START_BIT; endproperty
   a_start: assert property (p_start) else $error("no start bit");
   property p_end;
      s_free |-> o_resp_done && $past(o_cmd_out) == END_BIT;
   endproperty
   a_end: assert property (p_end) else $error("bad frame end");
   property p_pulse; o_resp_done |=> !o_resp_done && o_resp_ready; endproperty
   a_pulse: assert property (p_pulse) else $error("done too long");
   property p_idle; o_resp_ready |-> o_cmd_oe_n && o_cmd_out; endproperty
   a_idle: assert property (p_idle) else $error("line driven idle");
   // ------
   // Status word
   // ------
   // Event sets the sticky bit, the view register adds one more cycle
   property p_range; i_events.arg_range_fault |-> ##2 o_status_word[31];
   endproperty
   a_range: assert property (p_range) else $error("bit 31 not set");
   property p_crc;
      i_events.command_checksum_fault |-> ##2 o_status_word[23];
   endproperty
   a_crc: assert property (p_crc) else $error("bit 23 not set");
   property p_app; i_events.app_cmd_flag |-> ##2 o_status_word[5]; endproperty
   a_app: assert property (p_app) else $error("bit 5 not set");
   // Levels follow the card with one register stage
   property p_level;
      1'b1 |=> {o_status_word[LOCKED_POS], o_status_word[ECC_OFF_POS],
                o_status_word[BUF_EMPTY_POS]} == $past(i_levels);
   endproperty
   a_level: assert property (p_level) else $error("level bit");
   property p_rsvd; (o_status_word & 32'h0006_00D7) == 32'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit");
endmodule : resp_framer_chk
bind card_response_status_framer resp_framer_chk resp_framer_chk_inst (
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_resp_valid(i_resp_valid),
   .i_events(i_events), .i_levels(i_levels), .o_cmd_out(o_cmd_out),
   .o_cmd_oe_n(o_cmd_oe_n), .o_resp_ready(o_resp_ready),
   .o_resp_done(o_resp_done), .o_status_word(o_status_word));
`default_nettype wire

// ---- verif/tb_card_response_status_framer.sv ----
// Purpose : Self-checking bench of the card response framer
// Assumes : Host model owns the link clock, line pulled up
// Notes   : Expected frames and status come from a bench model
`timescale 1ns/10ps
`default_nettype none
module tb_card_response_status_framer;
   import resp_framer_pkg::*;
   // ------
   // Signals and rows: event index gives status bit
   // ------
   localparam int POS [17] = '{31, 30, 29, 28, 27, 26, 24, 23, 22, 21, 20,
                              19, 16, 15, 13, 5, 3};
   logic           clk, cmd_out, oe_n, ready, done;
   logic           rst = 1'b1, valid = 1'b0, strobe = 1'b0, ok = 1'b0;
   logic           b_arm = 1'b0;
   logic [3:0]     state = 4'h0, cur_state = 4'h0;
   logic [31:0]    sw, exp_c = 32'h0;
   resp_req_t      req = '0;
   status_events_t ev = '0;
   status_levels_t lv = '0;
   wire logic      link_clk, cmd_wire;
   int             miscompares = 0, num_checks = 0, done_cnt = 0, cycles = 0;
   // Pull-up holds the released line high
   assign cmd_wire = oe_n ? 1'b1 : cmd_out;
   card_response_status_framer card_response_status_framer_inst (
      .i_ref_clk(clk), .i_rst(rst), .i_link_clk(link_clk),
      .i_cmd_in(cmd_wire), .o_cmd_out(cmd_out), .o_cmd_oe_n(oe_n),
      .i_resp_valid(valid), .i_resp(req), .o_resp_ready(ready),
      .o_resp_done(done), .i_cmd_strobe(strobe), .i_cmd_ok(ok),
      .i_card_state(state), .i_events(ev), .i_levels(lv),
      .o_status_word(sw));
   host_link_model host_link_model_inst (.i_cmd_wire(cmd_wire),
      .o_link_clk(link_clk));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Done pulses; ceiling far above the roughly 10000 cycles of traffic
   always @(posedge clk)
   begin
      if (done === 1'b1)
         done_cnt++;
      cycles++;
      if (cycles == 40000)
      begin
         miscompares++;
         complete_run();
      end
   end
   // ------
   // Model and tasks
   // ------
   function automatic logic [31:0] cur();
      return exp_c | (32'(lv.locked_flag) << LOCKED_POS)
         | (32'(lv.ecc_off_flag) << ECC_OFF_POS)
         | (32'(lv.buffer_empty_flag) << BUF_EMPTY_POS)
         | (32'(cur_state) << STATE_LSB);
   endfunction : cur
   function automatic logic [6:0] crc7(input logic [135:0] f);
      logic [6:0] c;
      logic       b;
      c = CRC_RESET;
      for (int i = 47; i >= 8; i--)
      begin
         b = f[i] ^ c[6];
         c = {c[5:0], 1'b0} ^ (b ? CRC_POLY : 7'h00);
      end
      return c;
   endfunction : crc7
   task automatic chk(input logic [135:0] got, input logic [135:0] want);
      num_checks++;
      if (got !== want)
      begin
         $display("wrong value at %0t: got %h want %h", $time, got, want);
         miscompares++;
      end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run
   // A received command latches the state; a valid one arms class B
   task automatic cmd(input logic [3:0] s, input logic v);
      @(posedge clk);
      strobe <= 1'b1;
      ok <= v;
      state <= s;
      @(posedge clk);
      strobe <= 1'b0;
      cur_state = s;
      b_arm = b_arm | v;
      repeat (3) @(posedge clk);
      chk(136'(sw), 136'(cur()));
   endtask : cmd
   task automatic hit(input int i);
      @(posedge clk);
      ev <= status_events_t'(17'h1_0000 >> i);
      @(posedge clk);
      ev <= '0;
      exp_c[POS[i]] = 1'b1;
      repeat (3) @(posedge clk);
      chk(136'(sw), 136'(cur()));
   endtask : hit
   // Junk while busy must not reach the frame already taken
   task automatic send(input resp_kind_t k, input logic [5:0] idx);
      resp_req_t    r;
      logic [31:0]  s;
      logic [135:0] want;
      logic [135:0] got;
      int           d0;
      r = '{k, idx, 32'hA5C3_0F81, 16'h4D2B, {4{32'h96E1_3C5A}}};
      s = cur();
      case (k)
         RESP_R2: want = {2'b00, ALL_ONES_IDX, r.reg_bits[127:1], END_BIT};
         RESP_R3: want = {88'h0, 2'b00, ALL_ONES_IDX, r.ocr_word,
                          NO_CRC_FILL, END_BIT};
         RESP_R6: want = {88'h0, 2'b00, RCA_INDEX, r.rca, s[23:22], s[19],
                          s[12:0], 8'h00};
         default: want = {88'h0, 2'b00, idx, s, 8'h00};
      endcase
      if (k != RESP_R2 && k != RESP_R3)
         want[7:0] = {crc7(want), END_BIT};
      d0 = done_cnt;
      @(posedge clk);
      valid <= 1'b1;
      req <= r;
      @(posedge clk);
      req <= resp_req_t'(~r);
      if (k == RESP_R6)
         exp_c &= ~(CLASS_C_MASK & R6_MASK);
      else if (k != RESP_R2 && k != RESP_R3)
         exp_c &= ~CLASS_C_MASK;
      repeat (3) @(posedge clk);
      valid <= 1'b0;
      host_link_model_inst.capture((k == RESP_R2) ? 136 : 48, got);
      chk(got, want);
      chk(136'(done_cnt - d0), 136'(1));
      if (b_arm)
         exp_c &= ~CLASS_B_MASK;
      b_arm = 1'b0;
      repeat (3) @(posedge clk);
      chk(136'(sw), 136'(cur()));
   endtask : send
   // ------
   // Sequence
   // ------
   initial
   begin
      repeat (3) @(posedge clk);
      chk(136'({cmd_out, oe_n, done, ready, sw}), 136'({4'hD, 32'h0}));
      rst <= 1'b0;
      lv <= 3'b101;
      cmd(4'h4, 1'b0);
      for (int i = 0; i < 17; i++)
      begin
         hit(i);
         send(i[0] ? RESP_R1B : RESP_R1, 6'(63 - 3 * i));
      end
      // Class B bits drop only after the response to a valid command
      cmd(4'h5, 1'b1);
      send(RESP_R1, 6'h0D);
      // Address response reads back only its own status bits
      hit(0);
      hit(7);
      hit(11);
      hit(15);
      send(RESP_R6, 6'h03);
      send(RESP_R3, 6'h29);
      send(RESP_R2, 6'h02);
      lv <= 3'b010;
      for (int s = 0; s < 9; s++)
         cmd(4'(s), 1'b0);
      // Reset in mid-run drops sticky bits
      hit(2);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk(136'({cmd_out, oe_n, done, ready, sw}), 136'({4'hD, 32'h0}));
      rst <= 1'b0;
      exp_c = '0;
      cur_state = STATE_RESET;
      b_arm = 1'b0;
      repeat (3) @(posedge clk);
      send(RESP_R1, 6'h3F);
      complete_run();
   end
endmodule : tb_card_response_status_framer
`default_nettype wire
